// file: inc/acc_pkg.sv
package acc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W             = 5;
  localparam int          DATA_W             = 8;
  localparam int          RESULT_W           = 12;
  localparam logic [4:0]  ADDR_SIG_COND      = 5'h07;
  localparam logic [4:0]  ADDR_CONV_CTRL     = 5'h08;
  localparam logic [4:0]  ADDR_RESULT_UPPER  = 5'h09;
  localparam logic [4:0]  ADDR_RESULT_LOWER  = 5'h0a;
  localparam logic [7:0]  RESET_BYTE         = 8'h00;

  // ----------------------------------------------------------------
  // signal conditioning field positions
  // ----------------------------------------------------------------
  localparam int          SC_AMP_OFF_BIT     = 6;
  localparam int          SC_POLE2_LSB       = 4;
  localparam int          SC_POLE1_LSB       = 2;
  localparam int          SC_GAIN_LSB        = 0;

  // ----------------------------------------------------------------
  // converter control field positions
  // ----------------------------------------------------------------
  localparam int          CC_RATE_LSB        = 5;
  localparam int          CC_AUTO_BIT        = 4;
  localparam int          CC_READY_BIT       = 3;
  localparam int          CC_BUSY_BIT        = 2;
  localparam int          CC_START_BIT       = 1;
  localparam int          CC_BYPASS_BIT      = 0;

  // ----------------------------------------------------------------
  // codes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0]  POLE_400HZ         = 2'h0;
  localparam logic [1:0]  POLE_2KHZ          = 2'h1;
  localparam logic [1:0]  POLE_10KHZ         = 2'h2;
  localparam logic [1:0]  GAIN_UNUSED_CODE   = 2'h3;
  localparam logic [1:0]  GAIN_TEN_CODE      = 2'h2;
  localparam int          CLOCK_MHZ          = 50;
  localparam int          BASE_PERIOD_US     = 80;
  localparam int          BASE_PERIOD_CYC    = BASE_PERIOD_US * CLOCK_MHZ;
  localparam int          RATE_W             = 3;

  // settings applied to the analog conditioning path
  typedef struct packed {
    logic       amp_on;
    logic [1:0] pole2;
    logic [1:0] pole1;
    logic [1:0] gain;
  } acc_cond_t;

  typedef enum logic [0:0] {
    ACC_IDLE,
    ACC_CONVERT
  } acc_state_t;

endpackage

// file: verilog/acc_rate_timer.sv
// ------------------------------------------------------------------
// continuous-mode launch timer: base period times two to the n
// ------------------------------------------------------------------
module acc_rate_timer #(
  parameter int BASE_CYCLES = acc_pkg::BASE_PERIOD_CYC,
  parameter int RATE_W      = acc_pkg::RATE_W
) (
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_sys_rst,
  // control
  input  wire logic              i_run,
  input  wire logic [RATE_W-1:0] i_rate,
  // launch pulse
  output logic                   o_fire
);
  import acc_pkg::*;

  localparam int BASE_W  = $clog2(BASE_CYCLES + 1);
  localparam int SCALE_W = (1 << RATE_W);

  generate
    if (BASE_CYCLES < 1) begin : g_bad_base
      $error("acc_rate_timer: BASE_CYCLES must be at least one");
    end
    // the scaler top is built from a 32-bit shift, so N stays small
    if (RATE_W < 1 || RATE_W > 5) begin : g_bad_rate
      $error("acc_rate_timer: RATE_W must lie between one and five");
    end
  endgenerate

  logic [BASE_W-1:0]  base_q;
  logic [SCALE_W-1:0] scale_q;
  logic [SCALE_W-1:0] scale_top;
  wire                base_tick;
  wire                scale_hit;

  // base divider wraps every base period; scaler counts ticks to 2^n
  assign base_tick = (base_q == BASE_W'(BASE_CYCLES - 1));
  assign scale_top = SCALE_W'((1 << i_rate) - 1);
  assign scale_hit = base_tick && (scale_q >= scale_top);

  // counters rest at zero while idle so the first launch is a full period late
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      base_q  <= '0;
      scale_q <= '0;
      o_fire  <= 1'b0;
    end else if (!i_run) begin
      base_q  <= '0;
      scale_q <= '0;
      o_fire  <= 1'b0;
    end else begin
      base_q  <= base_tick ? '0 : base_q + BASE_W'(1);
      scale_q <= scale_hit ? '0 : (base_tick ? scale_q + SCALE_W'(1) : scale_q);
      o_fire  <= scale_hit;
    end
  end

endmodule // acc_rate_timer

// file: verilog/acc_conv_ctrl.sv
module acc_conv_ctrl #(
  parameter int BASE_CYCLES = acc_pkg::BASE_PERIOD_CYC
) (
  // clock and reset
  input  wire logic                            i_clock,
  input  wire logic                            i_sys_rst,
  // register port
  input  wire logic [acc_pkg::ADDR_W-1:0]      i_addr,
  input  wire logic                            i_wr_en,
  input  wire logic [acc_pkg::DATA_W-1:0]      i_wr_data,
  input  wire logic                            i_rd_en,
  output logic      [acc_pkg::DATA_W-1:0]      o_rd_data,
  // analog conditioning settings
  output acc_pkg::acc_cond_t                   o_cond,
  // converter core handshake
  output logic                                 o_conv_start,
  input  wire logic                            i_conv_done,
  input  wire logic [acc_pkg::RESULT_W-1:0]    i_conv_result,
  // status
  output logic                                 o_busy,
  output logic                                 o_data_ready
);
  import acc_pkg::*;

  generate
    if (BASE_CYCLES < 1) begin : g_bad_base
      $error("acc_conv_ctrl: BASE_CYCLES must be at least one");
    end
  endgenerate

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic                amp_off_q;
  logic [1:0]          pole2_q;
  logic [1:0]          pole1_q;
  logic [1:0]          gain_q;
  logic [RATE_W-1:0]   rate_q;
  logic                auto_q;
  logic                start_q;
  logic                bypass_q;
  logic                ready_q;
  logic [RESULT_W-1:0] result_q;
  acc_state_t          state_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire wr_cond   = i_wr_en && (i_addr == ADDR_SIG_COND);
  wire wr_ctrl   = i_wr_en && (i_addr == ADDR_CONV_CTRL);
  wire start_set = wr_ctrl && i_wr_data[CC_START_BIT];
  wire auto_fire;
  wire idle      = (state_q == ACC_IDLE);
  // a pending single request wins over the timer; both cost one conversion
  wire launch    = idle && (start_q || auto_fire);
  wire finish    = (state_q == ACC_CONVERT) && i_conv_done;

  // amplifier drives the converter only with both disable bits clear
  wire amp_on_d  = !amp_off_q && !bypass_q;
  // the unused gain code is mapped to its documented gain of ten
  wire [1:0] gain_eff = (gain_q == GAIN_UNUSED_CODE) ? GAIN_TEN_CODE : gain_q;

  // readback images, unused bits read zero
  wire [DATA_W-1:0] cond_img = {1'b0, amp_off_q, pole2_q, pole1_q, gain_q};
  wire [DATA_W-1:0] ctrl_img = {rate_q, auto_q, ready_q, (state_q == ACC_CONVERT),
                                start_q, bypass_q};
  wire [DATA_W-1:0] upper_img = result_q[RESULT_W-1 -: DATA_W];
  wire [DATA_W-1:0] lower_img = DATA_W'(result_q[RESULT_W-DATA_W-1:0]);
  wire [DATA_W-1:0] rd_mux   = (i_addr == ADDR_SIG_COND)     ? cond_img  :
                               (i_addr == ADDR_CONV_CTRL)    ? ctrl_img  :
                               (i_addr == ADDR_RESULT_UPPER) ? upper_img :
                               (i_addr == ADDR_RESULT_LOWER) ? lower_img : RESET_BYTE;

  // ----------------------------------------------------------------
  // continuous-mode timer
  // ----------------------------------------------------------------
  acc_rate_timer #(
    .BASE_CYCLES (BASE_CYCLES),
    .RATE_W      (RATE_W)
  ) u_timer (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_run     (auto_q),
    .i_rate    (rate_q),
    .o_fire    (auto_fire)
  );

  // ----------------------------------------------------------------
  // host-written fields
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      amp_off_q <= 1'b0;
      pole2_q   <= POLE_400HZ;
      pole1_q   <= POLE_400HZ;
      gain_q    <= 2'h0;
      rate_q    <= '0;
      auto_q    <= 1'b0;
      bypass_q  <= 1'b0;
    end else begin
      if (wr_cond) begin
        amp_off_q <= i_wr_data[SC_AMP_OFF_BIT];
        pole2_q   <= i_wr_data[SC_POLE2_LSB +: 2];
        pole1_q   <= i_wr_data[SC_POLE1_LSB +: 2];
        gain_q    <= i_wr_data[SC_GAIN_LSB +: 2];
      end
      if (wr_ctrl) begin
        rate_q   <= i_wr_data[CC_RATE_LSB +: RATE_W];
        auto_q   <= i_wr_data[CC_AUTO_BIT];
        bypass_q <= i_wr_data[CC_BYPASS_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // start request, ready flag and conversion sequencer
  // ----------------------------------------------------------------
  // a new start written in the launch cycle is kept, so no request is lost
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      start_q <= 1'b0;
      ready_q <= 1'b0;
      state_q <= ACC_IDLE;
    end else begin
      start_q <= start_set || (start_q && !launch);
      // finish sets, host start write or any launch (pending start or timer) clears; set wins
      ready_q <= finish || (ready_q && !start_set && !launch);
      unique case (state_q)
        ACC_IDLE:    if (launch) state_q <= ACC_CONVERT;
        ACC_CONVERT: if (i_conv_done) state_q <= ACC_IDLE;
      endcase
    end
  end

  // result holds until the next finish overwrites it
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      result_q <= '0;
    end else if (finish) begin
      result_q <= i_conv_result;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data    <= RESET_BYTE;
      o_cond       <= '0;
      o_conv_start <= 1'b0;
      o_busy       <= 1'b0;
      o_data_ready <= 1'b0;
    end else begin
      if (i_rd_en) o_rd_data <= rd_mux;
      o_cond       <= '{amp_on: amp_on_d, pole2: pole2_q, pole1: pole1_q,
                        gain: gain_eff};
      o_conv_start <= launch;
      o_busy       <= (state_q == ACC_CONVERT) ? !i_conv_done : launch;
      o_data_ready <= finish || (ready_q && !start_set && !launch);
    end
  end

endmodule // acc_conv_ctrl

// file: testbench/acc_conv_ctrl_props.sv
// ----------------------------------------------------------------
// converter control checker
// ----------------------------------------------------------------
module acc_conv_ctrl_props
  import acc_pkg::*;
#(parameter int BASE_CYCLES = 4) (
  // clock, reset and register port
  input wire logic              i_clock, i_sys_rst, i_wr_en, i_rd_en,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic [DATA_W-1:0] o_rd_data,
  // converter side and status
  input wire acc_cond_t           o_cond,
  input wire logic                o_conv_start, i_conv_done, o_busy, o_data_ready,
  input wire logic [RESULT_W-1:0] i_conv_result
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // host write of the one-shot start bit
  wire st_wr = i_wr_en && i_addr == ADDR_CONV_CTRL && i_wr_data[CC_START_BIT];
  // auto bit as last written; timer launches would mask a start write
  logic                auto_on_q;
  // result of the last completion, as the host should read it back
  logic [RESULT_W-1:0] last_q;
  wire  [DATA_W-1:0]   last_hi = last_q[RESULT_W-1 -: DATA_W];
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      auto_on_q <= 1'b0;
      last_q    <= '0;
    end else begin
      if (i_wr_en && i_addr == ADDR_CONV_CTRL) auto_on_q <= i_wr_data[CC_AUTO_BIT];
      if (o_busy && i_conv_done) last_q <= i_conv_result;
    end
  end

  a_start_busy: assert property (o_conv_start |-> o_busy)
    else $error("launch pulse without busy");
  a_busy_holds: assert property (o_busy && !i_conv_done |=> o_busy)
    else $error("busy dropped before completion");
  a_done_ends: assert property (o_busy && i_conv_done |=> !o_busy && o_data_ready)
    else $error("completion did not end busy and set ready");
  a_busy_cause: assert property ($rose(o_busy) |-> o_conv_start)
    else $error("busy rose without launch");
  a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
    else $error("launch pulse longer than one cycle");
  // a launch already under way at the write edge would hide the new request
  a_write_starts: assert property (st_wr && !o_busy && !o_conv_start && !auto_on_q &&
    !$past(st_wr) && !$past(o_busy) && !$past(auto_on_q) |-> ##2 o_conv_start)
    else $error("start write did not launch");
  a_start_clears: assert property (st_wr && !i_conv_done |=> !o_data_ready)
    else $error("start write left ready set");
  a_ready_falls: assert property ($fell(o_data_ready) |-> o_conv_start || $past(st_wr))
    else $error("ready cleared without cause");
  a_status_read: assert property (i_rd_en && i_addr == ADDR_CONV_CTRL |=>
    o_rd_data[CC_BUSY_BIT] == $past(o_busy) && o_rd_data[CC_READY_BIT] == $past(o_data_ready))
    else $error("status bits read back wrong");

  a_gain_mapped: assert property (o_cond.gain != GAIN_UNUSED_CODE)
    else $error("unused gain code reached the amplifier");
  a_upper_read: assert property (i_rd_en && i_addr == ADDR_RESULT_UPPER |=>
    o_rd_data == $past(last_hi))
    else $error("upper result byte read back wrong");

  c_done: cover property (o_busy && i_conv_done);
  c_relaunch: cover property ($fell(o_data_ready) && o_conv_start);
  c_pending: cover property (st_wr && o_busy);
endmodule // acc_conv_ctrl_props

bind acc_conv_ctrl acc_conv_ctrl_props #(.BASE_CYCLES(BASE_CYCLES)) props_u (.i_clock,
  .i_sys_rst, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data, .o_rd_data, .o_cond, .o_conv_start,
  .i_conv_done, .o_busy, .o_data_ready, .i_conv_result);

// file: testbench/acc_core_model.sv
// ----------------------------------------------------------------
// converter core stand-in: done pulse after a set latency
// ----------------------------------------------------------------
module acc_core_model (
  input  wire logic        i_clock,
  input  wire logic        i_start,
  input  wire logic [3:0]  i_latency,
  input  wire logic [11:0] i_value,
  output logic             o_done,
  output logic [11:0]      o_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q = 4'h0;
  initial o_done = 1'b0;
  initial o_result = 12'ha5a;
  // result bus toggles outside the done cycle so stale data never matches
  always @(posedge i_clock) begin
    o_done <= 1'b0;
    o_result <= ~o_result;
    if (i_start) begin
      cnt_q <= i_latency;
    end else if (cnt_q == 4'h1) begin
      o_done <= 1'b1;
      o_result <= i_value;
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule // acc_core_model

// file: testbench/test_adc_conversion_control.sv
module test_adc_conversion_control;
  timeunit 1ns;
  timeprecision 1ps;
  import acc_pkg::*;
  localparam int BASE = 8; // short, yet longer than a conversion so no fire is dropped
  logic        clock = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [7:0]  wdata = 8'h00, rdata, d;
  logic [3:0]  lat = 4'h3;
  logic [11:0] value = 12'h000, result;
  logic        conv_start, done, busy, ready;
  acc_cond_t   cond;
  logic [7:0]  exp_q[$];
  integer      seed = 32'hf10c054a;
  int          n_fail = 0, samples_checked = 0, n_starts = 0, cyc = 0, last = 0, gap = 0, i, w;

  always #10 clock = ~clock;
  acc_conv_ctrl #(.BASE_CYCLES(BASE)) dut_u (.i_clock(clock), .i_sys_rst(sys_rst),
    .i_addr(addr), .i_wr_en(wr), .i_wr_data(wdata), .i_rd_en(rd), .o_rd_data(rdata),
    .o_cond(cond), .o_conv_start(conv_start), .i_conv_done(done),
    .i_conv_result(result), .o_busy(busy), .o_data_ready(ready));
  acc_core_model core_u (.i_clock(clock), .i_start(conv_start), .i_latency(lat),
    .i_value(value), .o_done(done), .o_result(result));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one strobe cycle then one idle cycle; reads note their expectation
  task automatic reg_op(input logic is_rd, input logic [4:0] a, input logic [7:0] v);
    addr = a;
    wdata = v;
    wr = !is_rd;
    rd = is_rd;
    if (is_rd) exp_q.push_back(v);
    @(negedge clock);
    wr = 1'b0;
    rd = 1'b0;
    @(negedge clock);
  endtask

  // bounded wait for a launch count with the converter idle
  task automatic wait_starts(input int want);
    int k;
    for (k = 0; k < 4000 && !(n_starts >= want && !busy); k++) @(negedge clock);
    if (k == 4000) check(16'h0000, 16'h0001);
  endtask

  // launch bookkeeping and read-data scoreboard
  always @(posedge clock) begin
    rd_seen <= rd;
    cyc <= cyc + 1;
    if (conv_start) begin
      n_starts <= n_starts + 1;
      gap <= cyc - last;
      last <= cyc;
    end
  end
  always @(negedge clock) if (rd_seen) check({8'h00, rdata}, {8'h00, exp_q.pop_front()});

  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    for (i = 7; i < 12; i++) reg_op(1'b1, 5'(i), 8'h00);
    $display("reset values done");
    for (i = 0; i < 4; i++) begin
      d = {1'b0, 1'($random(seed)), 2'(i), 2'(i), 2'(i)};
      reg_op(1'b0, ADDR_SIG_COND, d);
      reg_op(1'b1, ADDR_SIG_COND, d);
      check({9'h0, cond}, {9'h0, ~d[6], d[5:2],
        (d[1:0] == 2'h3) ? GAIN_TEN_CODE : d[1:0]});
    end
    reg_op(1'b0, ADDR_CONV_CTRL, 8'h01);
    reg_op(1'b1, ADDR_CONV_CTRL, 8'h01);
    check({15'h0, cond.amp_on}, 16'h0000);
    reg_op(1'b0, ADDR_SIG_COND, 8'h2a);
    reg_op(1'b0, ADDR_CONV_CTRL, 8'h00);
    check({15'h0, cond.amp_on}, 16'h0001);
    $display("conditioning done");
    for (i = 0; i < 2; i++) begin
      value = 12'($random(seed));
      w = n_starts + 1 + i;
      reg_op(1'b0, ADDR_CONV_CTRL, 8'h02);
      check({15'h0, ready}, 16'h0000);
      if (i == 1) reg_op(1'b0, ADDR_CONV_CTRL, 8'h02); // second request while busy
      wait_starts(w);
      reg_op(1'b1, ADDR_RESULT_UPPER, value[11:4]);
      reg_op(1'b1, ADDR_RESULT_LOWER, {4'h0, value[3:0]});
      reg_op(1'b1, ADDR_CONV_CTRL, 8'h08);
      check(16'(n_starts), 16'(w));
    end
    $display("single conversions done");
    lat = 4'h2;
    for (i = 0; i < 8; i++) begin
      value = 12'($random(seed));
      reg_op(1'b0, ADDR_CONV_CTRL, {3'(i), 5'h10});
      wait_starts(n_starts + 3);
      check(16'(gap), 16'(BASE << i));
      reg_op(1'b1, ADDR_RESULT_UPPER, value[11:4]);
      reg_op(1'b0, ADDR_CONV_CTRL, 8'h00);
      wait_starts(n_starts);
    end
    $display("continuous rates done");
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    reg_op(1'b1, ADDR_SIG_COND, 8'h00);
    $display("second reset done");
    end_of_test;
  end

  // watchdog well beyond the few thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    end_of_test;
  end
endmodule // test_adc_conversion_control
